// ===== rtl/smptl_consts.vh
// Constants for the management transport layer state machines
`ifndef SMPTL_CONSTS_VH
`define SMPTL_CONSTS_VH
`define SMPTL_TYPE_REQ 8'h40
`define SMPTL_TYPE_RSP 8'h41
`define SMPTL_CONN_TAG 16'hffff
`define SMPTL_MAX_BYTES 1024
`define SMPTL_RSP_LIMIT_US 1900
`define SMPTL_CLK_MHZ 25
`define SMPTL_LEN_W 11
`define SMPTL_ALIGN_MASK 11'h003
`define SMPTL_TX_OK 2'h0
`endif

// ===== rtl/smptl_initiator.v
// Initiator-side transport state machine
`timescale 1ns/1ps
`include "smptl_consts.vh"
module smptl_initiator #(
	parameter ADDR_W = 64
) (
	input wire clk,
	input wire nrst,
	input wire [ADDR_W-1:0] own_addr,
	input wire req_valid,
	input wire [3:0] req_rate,
	input wire [ADDR_W-1:0] req_dest,
	input wire [`SMPTL_LEN_W-1:0] req_len,
	input wire tx_status_valid,
	input wire [1:0] tx_status,
	input wire conn_closed,
	input wire rx_valid,
	input wire [7:0] rx_type,
	input wire rx_fail,
	output reg req_ready,
	output reg tx_req,
	output reg tx_init_bit,
	output reg [15:0] tx_tag,
	output reg [3:0] tx_rate,
	output reg [ADDR_W-1:0] tx_dest,
	output reg [ADDR_W-1:0] tx_src,
	output reg [7:0] tx_type,
	output reg [`SMPTL_LEN_W-1:0] tx_len,
	output reg [1:0] tx_fill,
	output reg conf_open_failed,
	output reg conf_complete,
	output reg conf_xfer_failed
);
	localparam ST_WAIT = 2'h0;
	localparam ST_SEND = 2'h1;
	localparam ST_AWAIT = 2'h2;
	reg [1:0] state_reg;
	// Fill count to reach a four-byte boundary; header byte counted
	function [1:0] fill_of;
		input [`SMPTL_LEN_W-1:0] len;
		reg [`SMPTL_LEN_W-1:0] tot;
		begin
			tot = len + 11'h001;
			fill_of = 2'h0 - tot[1:0];
		end
	endfunction
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ST_WAIT;
			req_ready <= 1'b1;
			tx_req <= 1'b0;
			tx_init_bit <= 1'b0;
			tx_tag <= 16'h0000;
			tx_rate <= 4'h0;
			tx_dest <= {ADDR_W{1'b0}};
			tx_src <= {ADDR_W{1'b0}};
			tx_type <= 8'h00;
			tx_len <= {`SMPTL_LEN_W{1'b0}};
			tx_fill <= 2'h0;
			conf_open_failed <= 1'b0;
			conf_complete <= 1'b0;
			conf_xfer_failed <= 1'b0;
		end else begin
			tx_req <= 1'b0;
			conf_open_failed <= 1'b0;
			conf_complete <= 1'b0;
			conf_xfer_failed <= 1'b0;
			case (state_reg)
			ST_WAIT: begin
				if (req_valid) begin
					state_reg <= ST_SEND;
					req_ready <= 1'b0;
					tx_req <= 1'b1;
					tx_init_bit <= 1'b1;
					tx_tag <= `SMPTL_CONN_TAG;
					tx_rate <= req_rate;
					tx_dest <= req_dest;
					tx_src <= own_addr;
					tx_type <= `SMPTL_TYPE_REQ;
					tx_len <= req_len;
					tx_fill <= fill_of(req_len);
				end
			end
			ST_SEND: begin
				if (conn_closed || (tx_status_valid && tx_status != `SMPTL_TX_OK)) begin
					conf_open_failed <= 1'b1;
					state_reg <= ST_WAIT;
					req_ready <= 1'b1;
				end else if (tx_status_valid) begin
					state_reg <= ST_AWAIT;
				end
			end
			ST_AWAIT: begin
				// Closure or failure takes priority over a good frame
				if (conn_closed || (rx_valid && rx_fail)) begin
					conf_xfer_failed <= 1'b1;
					state_reg <= ST_WAIT;
					req_ready <= 1'b1;
				end else if (rx_valid) begin
					conf_complete <= (rx_type == `SMPTL_TYPE_RSP);
					conf_xfer_failed <= (rx_type != `SMPTL_TYPE_RSP);
					state_reg <= ST_WAIT;
					req_ready <= 1'b1;
				end
			end
			default: begin
				state_reg <= ST_WAIT;
				req_ready <= 1'b1;
			end
			endcase
		end
	end
endmodule // smptl_initiator

// ===== rtl/smptl_target.v
// Target-side transport state machine
`timescale 1ns/1ps
`include "smptl_consts.vh"
module smptl_target #(
	parameter LIMIT_CYC = `SMPTL_RSP_LIMIT_US * `SMPTL_CLK_MHZ
) (
	input wire clk,
	input wire nrst,
	input wire rx_valid,
	input wire [7:0] rx_type,
	input wire acc_valid,
	input wire acc_accept,
	input wire rsp_valid,
	input wire [`SMPTL_LEN_W-1:0] rsp_len,
	input wire tx_status_valid,
	input wire [1:0] tx_status,
	input wire conn_closed,
	output reg conf_func_rcvd,
	output reg tx_break,
	output reg pl_acc_valid,
	output reg pl_acc_accept,
	output reg tx_req,
	output reg [7:0] tx_type,
	output reg [`SMPTL_LEN_W-1:0] tx_len,
	output reg [1:0] tx_fill,
	output reg conf_conn_closed,
	output reg rsp_timeout
);
	localparam ST_WAIT = 1'b0;
	localparam ST_REPLY = 1'b1;
	reg state_reg;
	reg [15:0] timer_reg;
	reg sent_reg;
	function [1:0] fill_of;
		input [`SMPTL_LEN_W-1:0] len;
		reg [`SMPTL_LEN_W-1:0] tot;
		begin
			tot = len + 11'h001;
			fill_of = 2'h0 - tot[1:0];
		end
	endfunction
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ST_WAIT;
			timer_reg <= 16'h0000;
			sent_reg <= 1'b0;
			conf_func_rcvd <= 1'b0;
			tx_break <= 1'b0;
			pl_acc_valid <= 1'b0;
			pl_acc_accept <= 1'b0;
			tx_req <= 1'b0;
			tx_type <= 8'h00;
			tx_len <= {`SMPTL_LEN_W{1'b0}};
			tx_fill <= 2'h0;
			conf_conn_closed <= 1'b0;
			rsp_timeout <= 1'b0;
		end else begin
			conf_func_rcvd <= 1'b0;
			tx_break <= 1'b0;
			pl_acc_valid <= 1'b0;
			tx_req <= 1'b0;
			conf_conn_closed <= 1'b0;
			rsp_timeout <= 1'b0;
			case (state_reg)
			ST_WAIT: begin
				if (acc_valid) begin
					pl_acc_valid <= 1'b1;
					pl_acc_accept <= acc_accept;
				end
				if (rx_valid) begin
					if (rx_type != `SMPTL_TYPE_REQ) begin
						tx_break <= 1'b1;
					end else begin
						conf_func_rcvd <= 1'b1;
						state_reg <= ST_REPLY;
						timer_reg <= 16'h0000;
						sent_reg <= 1'b0;
					end
				end
			end
			ST_REPLY: begin
				if (timer_reg != 16'hffff) begin
					timer_reg <= timer_reg + 16'h0001;
				end
				// Late reply is still sent, but flagged so the app can see it
				if (timer_reg == LIMIT_CYC[15:0] - 16'h0002 && !sent_reg) begin
					rsp_timeout <= 1'b1;
				end
				if (conn_closed) begin
					conf_conn_closed <= 1'b1;
					state_reg <= ST_WAIT;
				end else if (sent_reg && tx_status_valid) begin
					state_reg <= ST_WAIT;
				end else if (rsp_valid && !sent_reg) begin
					tx_req <= 1'b1;
					sent_reg <= 1'b1;
					tx_type <= `SMPTL_TYPE_RSP;
					tx_len <= rsp_len;
					tx_fill <= fill_of(rsp_len);
				end
			end
			default: state_reg <= ST_WAIT;
			endcase
		end
	end
endmodule // smptl_target

// ===== rtl/smptl_top.v
// Management transport layer: initiator and target machines
`timescale 1ns/1ps
`include "smptl_consts.vh"
module smptl_top #(
	parameter ADDR_W = 64,
	parameter RSP_LIMIT_CYC = `SMPTL_RSP_LIMIT_US * `SMPTL_CLK_MHZ
) (
	input wire clk,
	input wire nrst,
	input wire [ADDR_W-1:0] own_addr,
	input wire i_req_valid,
	input wire [3:0] i_req_rate,
	input wire [ADDR_W-1:0] i_req_dest,
	input wire [`SMPTL_LEN_W-1:0] i_req_len,
	input wire i_tx_status_valid,
	input wire [1:0] i_tx_status,
	input wire i_conn_closed,
	input wire i_rx_valid,
	input wire [7:0] i_rx_type,
	input wire i_rx_fail,
	output wire i_req_ready,
	output wire i_tx_req,
	output wire i_tx_init_bit,
	output wire [15:0] i_tx_tag,
	output wire [3:0] i_tx_rate,
	output wire [ADDR_W-1:0] i_tx_dest,
	output wire [ADDR_W-1:0] i_tx_src,
	output wire [7:0] i_tx_type,
	output wire [`SMPTL_LEN_W-1:0] i_tx_len,
	output wire [1:0] i_tx_fill,
	output wire i_conf_open_failed,
	output wire i_conf_complete,
	output wire i_conf_xfer_failed,
	input wire t_rx_valid,
	input wire [7:0] t_rx_type,
	input wire t_acc_valid,
	input wire t_acc_accept,
	input wire t_rsp_valid,
	input wire [`SMPTL_LEN_W-1:0] t_rsp_len,
	input wire t_tx_status_valid,
	input wire [1:0] t_tx_status,
	input wire t_conn_closed,
	output wire t_conf_func_rcvd,
	output wire t_tx_break,
	output wire t_pl_acc_valid,
	output wire t_pl_acc_accept,
	output wire t_tx_req,
	output wire [7:0] t_tx_type,
	output wire [`SMPTL_LEN_W-1:0] t_tx_len,
	output wire [1:0] t_tx_fill,
	output wire t_conf_conn_closed,
	output wire t_rsp_timeout
);
	// Both submodules register every output, so these are flop outputs
	smptl_initiator #(.ADDR_W(ADDR_W)) u_init (
		.clk(clk),
		.nrst(nrst),
		.own_addr(own_addr),
		.req_valid(i_req_valid),
		.req_rate(i_req_rate),
		.req_dest(i_req_dest),
		.req_len(i_req_len),
		.tx_status_valid(i_tx_status_valid),
		.tx_status(i_tx_status),
		.conn_closed(i_conn_closed),
		.rx_valid(i_rx_valid),
		.rx_type(i_rx_type),
		.rx_fail(i_rx_fail),
		.req_ready(i_req_ready),
		.tx_req(i_tx_req),
		.tx_init_bit(i_tx_init_bit),
		.tx_tag(i_tx_tag),
		.tx_rate(i_tx_rate),
		.tx_dest(i_tx_dest),
		.tx_src(i_tx_src),
		.tx_type(i_tx_type),
		.tx_len(i_tx_len),
		.tx_fill(i_tx_fill),
		.conf_open_failed(i_conf_open_failed),
		.conf_complete(i_conf_complete),
		.conf_xfer_failed(i_conf_xfer_failed)
	);
	smptl_target #(.LIMIT_CYC(RSP_LIMIT_CYC)) u_targ (
		.clk(clk),
		.nrst(nrst),
		.rx_valid(t_rx_valid),
		.rx_type(t_rx_type),
		.acc_valid(t_acc_valid),
		.acc_accept(t_acc_accept),
		.rsp_valid(t_rsp_valid),
		.rsp_len(t_rsp_len),
		.tx_status_valid(t_tx_status_valid),
		.tx_status(t_tx_status),
		.conn_closed(t_conn_closed),
		.conf_func_rcvd(t_conf_func_rcvd),
		.tx_break(t_tx_break),
		.pl_acc_valid(t_pl_acc_valid),
		.pl_acc_accept(t_pl_acc_accept),
		.tx_req(t_tx_req),
		.tx_type(t_tx_type),
		.tx_len(t_tx_len),
		.tx_fill(t_tx_fill),
		.conf_conn_closed(t_conf_conn_closed),
		.rsp_timeout(t_rsp_timeout)
	);
endmodule // smptl_top

// ===== verif/smptl_top_properties.sv
// Port-level properties of the management transport layer
`timescale 1ns/1ps
`include "smptl_consts.vh"
module smptl_chk (
	input wire clk,
	input wire nrst,
	input wire i_req_valid,
	input wire i_req_ready,
	input wire i_tx_req,
	input wire i_tx_init_bit,
	input wire [15:0] i_tx_tag,
	input wire [7:0] i_tx_type,
	input wire [`SMPTL_LEN_W-1:0] i_tx_len,
	input wire [1:0] i_tx_fill,
	input wire i_rx_valid,
	input wire [7:0] i_rx_type,
	input wire i_rx_fail,
	input wire i_conn_closed,
	input wire i_conf_open_failed,
	input wire i_conf_complete,
	input wire i_conf_xfer_failed,
	input wire t_rx_valid,
	input wire [7:0] t_rx_type,
	input wire t_tx_break,
	input wire t_conf_func_rcvd,
	input wire t_tx_req,
	input wire [7:0] t_tx_type,
	input wire t_conn_closed,
	input wire t_conf_conn_closed,
	input wire t_acc_valid,
	input wire t_acc_accept,
	input wire t_pl_acc_valid,
	input wire t_pl_acc_accept
);
default clocking @(posedge clk); endclocking
default disable iff (!nrst);
a_req_to_send: assert property (i_req_valid && i_req_ready |=> i_tx_req && !i_req_ready)
	else $error("request not turned into a transmit");
a_send_fields: assert property (i_tx_req |-> i_tx_init_bit && i_tx_tag == 16'hffff && i_tx_type == 8'h40)
	else $error("bad transmit fields");
a_fill_align: assert property (i_tx_req |-> ({1'b0, i_tx_len} + 12'h1 + i_tx_fill) % 4 == 0)
	else $error("fill does not align");
a_conf_idle: assert property (i_conf_open_failed || i_conf_complete || i_conf_xfer_failed |-> i_req_ready)
	else $error("confirmation without idle");
a_complete_cause: assert property (i_conf_complete |-> $past(i_rx_valid) && !$past(i_rx_fail) && $past(i_rx_type) == 8'h41)
	else $error("complete without reply");
a_fail_cause: assert property (i_conf_xfer_failed |-> $past(i_conn_closed) || $past(i_rx_valid) && ($past(i_rx_fail) || $past(i_rx_type) != 8'h41))
	else $error("transfer failure without cause");
a_break_cause: assert property (t_tx_break |-> $past(t_rx_valid) && $past(t_rx_type) != 8'h40)
	else $error("break without bad frame");
a_func_cause: assert property (t_conf_func_rcvd |-> $past(t_rx_valid) && $past(t_rx_type) == 8'h40)
	else $error("function received without request");
a_reply_type: assert property (t_tx_req |-> t_tx_type == 8'h41)
	else $error("reply frame type wrong");
a_close_conf: assert property (t_conf_conn_closed |-> $past(t_conn_closed))
	else $error("connection-closed confirmation without close");
a_accept_pass: assert property (t_pl_acc_valid |-> $past(t_acc_valid) && t_pl_acc_accept == $past(t_acc_accept))
	else $error("accept decision not passed unchanged");
endmodule // smptl_chk
bind smptl_top smptl_chk u_chk (.*);

// ===== verif/smptl_port_model.sv
// Port layer model below the initiator machine
`timescale 1ns/1ps
module smptl_port_model (
	input wire clk,
	input wire i_tx_req,
	input wire [1:0] m_st,
	input wire [1:0] m_cls,
	input wire [7:0] m_rt,
	input wire m_rf,
	input wire [7:0] m_dly,
	output logic i_tx_status_valid = 1'b0,
	output logic [1:0] i_tx_status = 2'h0,
	output logic i_conn_closed = 1'b0,
	output logic i_rx_valid = 1'b0,
	output logic [7:0] i_rx_type = 8'h0,
	output logic i_rx_fail = 1'b0
);
always begin
	@(posedge clk iff i_tx_req);
	repeat (m_dly) @(posedge clk);
	#1;
	if (m_cls == 2'h1) i_conn_closed = 1'b1;
	else begin
		i_tx_status_valid = 1'b1;
		i_tx_status = m_st;
	end
	@(posedge clk);
	#1;
	// Released fields flip so stale values never look valid
	i_conn_closed = 1'b0;
	i_tx_status_valid = 1'b0;
	i_tx_status = ~i_tx_status;
	if (m_cls != 2'h1 && m_st == 2'h0) begin
		// At least one edge so the reply keeps the usual drive offset
		repeat (m_dly + 1) @(posedge clk);
		#1;
		if (m_cls == 2'h2) i_conn_closed = 1'b1;
		else begin
			i_rx_valid = 1'b1;
			i_rx_type = m_rt;
			i_rx_fail = m_rf;
		end
		@(posedge clk);
		#1;
		i_conn_closed = 1'b0;
		i_rx_valid = 1'b0;
		i_rx_type = ~i_rx_type;
		i_rx_fail = ~i_rx_fail;
	end
end
endmodule // smptl_port_model

// ===== verif/smptl_top_tb_top.sv
// Self-checking bench for the management transport layer
`timescale 1ns/1ps
`include "smptl_consts.vh"
module smptl_top_tb_top;
logic clk = 1'b0, nrst = 1'b0, i_req_valid = 1'b0, t_rx_valid = 1'b0, t_acc_valid = 1'b0;
logic t_acc_accept = 1'b0, t_rsp_valid = 1'b0, t_tx_status_valid = 1'b0, t_conn_closed = 1'b0;
logic [63:0] own_addr = 64'h0123_4567_89ab_cdef, i_req_dest = 64'h0, i_tx_dest, i_tx_src;
logic [3:0] i_req_rate = 4'h0, i_tx_rate;
logic [`SMPTL_LEN_W-1:0] i_req_len = 11'h0, t_rsp_len = 11'h0, i_tx_len, t_tx_len;
logic [7:0] t_rx_type = 8'h0, i_rx_type, i_tx_type, t_tx_type, m_rt = 8'h41, m_dly = 8'h0;
logic [1:0] t_tx_status = 2'h0, i_tx_status, i_tx_fill, t_tx_fill, m_st = 2'h0, m_cls = 2'h0;
logic [15:0] i_tx_tag;
logic [8:0] seen;
logic m_rf = 1'b0, i_tx_status_valid, i_conn_closed, i_rx_valid, i_rx_fail, i_req_ready;
logic i_tx_req, i_tx_init_bit, i_conf_open_failed, i_conf_complete, i_conf_xfer_failed;
logic t_conf_func_rcvd, t_tx_break, t_pl_acc_valid, t_pl_acc_accept, t_tx_req;
logic t_conf_conn_closed, t_rsp_timeout;
int bad_count = 0, n_tests = 0;
smptl_top #(.RSP_LIMIT_CYC(20)) DUT (.*);
smptl_port_model u_pl (.*);
always #20 clk = ~clk;
task chk(input logic [63:0] got, input logic [63:0] exp);
	n_tests++;
	if (got !== exp) begin
		bad_count++;
		$display("mismatch at %0t: got %h exp %h", $time, got, exp);
	end
endtask
// Sample once per cycle just after the edge; pulses last a full cycle
task step(input int n);
	repeat (n) begin
		@(posedge clk);
		#1;
		seen = seen | {i_conf_open_failed, i_conf_complete, i_conf_xfer_failed, t_conf_func_rcvd,
			t_tx_break, t_pl_acc_valid, t_tx_req, t_conf_conn_closed, t_rsp_timeout};
	end
endtask
task ireq(input logic [10:0] len);
	chk(i_req_ready, 64'h1);
	i_req_valid = 1'b1;
	i_req_rate = 4'h9;
	i_req_dest = 64'h5000_0000_0000_00a1;
	i_req_len = len;
	step(1);
	i_req_valid = 1'b0;
endtask
task tgo(input logic [4:0] v);
	{t_rx_valid, t_acc_valid, t_rsp_valid, t_tx_status_valid, t_conn_closed} = v;
	step(1);
	{t_rx_valid, t_acc_valid, t_rsp_valid, t_tx_status_valid, t_conn_closed} = 5'h0;
	t_rx_type = ~t_rx_type;
endtask
task test_init_ok;
	m_dly = 8'h3;
	seen = 9'h0;
	ireq(11'h5);
	step(1);
	chk(i_req_ready, 64'h0);
	// A request while busy must leave the frame fields alone
	i_req_valid = 1'b1;
	i_req_rate = 4'h3;
	step(1);
	i_req_valid = 1'b0;
	step(10);
	chk(seen, 9'h080);
	chk({i_tx_init_bit, i_tx_tag, i_tx_type, i_tx_rate}, {1'b1, 16'hffff, 8'h40, 4'h9});
	chk(i_tx_len, 64'h5);
	chk(i_tx_dest, i_req_dest);
	chk(i_tx_src, own_addr);
	chk(i_tx_fill, 2'h2);
	$display("test_init_ok done");
endtask
task automatic test_init_fail;
	logic [1:0] st [6] = '{2'h1, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0};
	logic [1:0] cl [6] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h2};
	logic [7:0] rt [6] = '{8'h41, 8'h41, 8'h41, 8'h42, 8'h41, 8'h41};
	logic [2:0] ex [6] = '{3'h4, 3'h4, 3'h4, 3'h1, 3'h1, 3'h1};
	m_dly = 8'h0;
	for (int k = 0; k < 6; k++) begin
		{m_st, m_cls, m_rt, m_rf, seen} = {st[k], cl[k], rt[k], k == 4, 9'h0};
		ireq(11'h400);
		step(6);
		chk(seen, {ex[k], 6'h0});
	end
	chk(i_tx_fill, 2'h3);
	$display("test_init_fail done");
endtask
task test_target;
	t_rx_type = 8'h7e;
	seen = 9'h0;
	tgo(5'h10);
	chk(seen, 9'h010);
	for (int a = 0; a < 2; a++) begin
		t_acc_accept = a[0];
		seen = 9'h0;
		tgo(5'h08);
		chk({seen, t_pl_acc_accept}, {9'h008, a[0]});
	end
	t_rx_type = 8'h40;
	seen = 9'h0;
	tgo(5'h10);
	t_rx_type = 8'h7e;
	tgo(5'h10);
	chk(seen, 9'h020);
	t_rsp_len = 11'h400;
	tgo(5'h04);
	chk({seen, t_tx_type, t_tx_fill}, {9'h024, 8'h41, 2'h3});
	chk(t_tx_len, 64'h400);
	tgo(5'h02);
	t_rx_type = 8'h40;
	seen = 9'h0;
	tgo(5'h10);
	tgo(5'h01);
	chk(seen, 9'h022);
	t_rx_type = 8'h40;
	seen = 9'h0;
	tgo(5'h10);
	step(15);
	chk(seen, 9'h020);
	step(8);
	chk(seen, 9'h021);
	tgo(5'h01);
	$display("test_target done");
endtask
task tally_and_finish;
	$display("comparisons %0d mismatches %0d", n_tests, bad_count);
	if (bad_count == 0 && n_tests > 0) $display("Result: passed");
	else $display("Result: failed");
	$finish;
endtask
initial begin
	repeat (10) @(posedge clk);
	#1;
	nrst = 1'b1;
	test_init_ok;
	test_init_fail;
	test_target;
	tally_and_finish;
end
// Whole run needs about 100 cycles; allow far more
initial begin
	#200000;
	bad_count++;
	tally_and_finish;
end
endmodule // smptl_top_tb_top
